//--- design/gdcd_top.sv
/*
  GPIB instrument-side interface: command and address decoding, talker,
  listener, serial poll and remote/lockout state, listener byte
  acceptance with NRFD hold-off, talker data drive.
  Assumes the controller owns ATN, IFC, REN and DAV; the byte handshake
  as talker is done by the instrument through talk_* ports.
*/
`timescale 1ns/1ps
module gdcd_top
  import gdcd_pkg::*;
#(
  parameter int DEPTH = 8
) (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic [4:0] prim_addr,
  input  wire logic       atn_pin,
  input  wire logic       ifc_pin,
  input  wire logic       ren_pin,
  input  wire logic       dav_pin,
  input  wire logic [7:0] dio_pin_in,
  output logic      [7:0] dio_out,
  output logic            dio_oe,
  output logic            nrfd_oe,
  output logic            ndac_oe,
  output logic            srq_oe,
  input  wire logic       talk_valid,
  input  wire logic [7:0] talk_data,
  input  wire logic [7:0] status_byte,
  input  wire logic       srq_req,
  input  wire logic       srq_pwr_on,
  input  wire logic       fast_xmit_in,
  input  wire logic       rd_ready,
  output logic            rd_valid,
  output logic      [7:0] rd_data,
  output logic            talker,
  output logic            listener,
  output logic            spoll,
  output logic            remote,
  output logic            lockout,
  output logic            fast_xmit,
  output gdcd_evt_t       evt
);
  localparam int AW = $clog2(DEPTH);

  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_depth_bad
    $error("gdcd_top DEPTH must be a power of two, at least 2");
  end

  function automatic logic [6:0] addr_plus(input logic [4:0] a,
                                           input logic [6:0] ofs);
    addr_plus = {2'b00, a} + ofs;
  endfunction

  gdcd_bus_t        bus;
  logic      [11:0] sync_w;
  logic      [4:0]  addr_q;
  logic             dav_q;
  gdcd_hs_t         hs_q, hs_d;
  logic             talk_q, talk_d, lsn_q, lsn_d, spe_q, spe_d;
  logic             rem_q, rem_d, llo_q, llo_d;
  logic             pend_talk_q, pend_talk_d, pend_lsn_q, pend_lsn_d;
  logic      [AW:0] wp_q, wp_d, rp_q, rp_d;
  logic             rv_q, rv_d;
  logic      [7:0]  dout_q, dout_d;
  logic             doe_q, doe_d, srq_q, srq_d, fx_q;
  gdcd_evt_t        evt_q, evt_d;
  logic             ndac_q, ndac_d, nrfd_q, nrfd_d;
  logic             full_w, byte_w, wr_w, pop_w;
  logic      [6:0]  cmd_w;

  gdcd_sync #(.WIDTH(12)) u_sync (
    .clk      (clk),
    .rst      (rst),
    .async_in ({atn_pin, ifc_pin, ren_pin, dav_pin, dio_pin_in}),
    .sync_out (sync_w)
  );
  assign bus = sync_w;

  gdcd_mem #(.WIDTH(8), .DEPTH(DEPTH)) u_mem (
    .clk     (clk),
    .wr_en   (wr_w),
    .wr_addr (wp_q[AW-1:0]),
    .wr_data (bus.dio),
    .rd_addr (rp_d[AW-1:0]),
    .rd_data (rd_data)
  );

  // Address followed every cycle after reset; a value above the legal range is ignored and the last one kept
  always_ff @(posedge clk) begin
    if (rst) begin
      addr_q <= GDCD_ADDR_RST;
    end else if (prim_addr <= GDCD_ADDR_MAX) begin
      addr_q <= prim_addr;
    end
  end

  assign cmd_w  = bus.dio[6:0];
  assign full_w = (wp_q[AW-1:0] == rp_q[AW-1:0]) && (wp_q[AW] != rp_q[AW]);
  // Byte taken on DAV rising edge during our acceptance window
  assign byte_w = bus.dav && !dav_q && (hs_q == GDCD_HS_IDLE);
  assign wr_w   = byte_w && !bus.atn && lsn_q && !full_w;
  assign pop_w  = rv_q && rd_ready;

  always_comb begin
    talk_d      = talk_q;
    lsn_d       = lsn_q;
    spe_d       = spe_q;
    rem_d       = rem_q;
    llo_d       = llo_q;
    pend_talk_d = pend_talk_q;
    pend_lsn_d  = pend_lsn_q;
    evt_d       = '0;
    wp_d        = wp_q;
    rp_d        = rp_q;
    srq_d       = srq_req | (srq_q & srq_pwr_on);
    if (wr_w) begin
      wp_d = wp_q + 1'b1;
    end
    if (pop_w) begin
      rp_d = rp_q + 1'b1;
    end
    if (byte_w && bus.atn) begin
      if (cmd_w == addr_plus(addr_q, GDCD_TALK_OFS)) begin
        pend_talk_d = 1'b1;
        pend_lsn_d  = 1'b0;
        lsn_d       = 1'b0;
      end else if (cmd_w == addr_plus(addr_q, GDCD_LISTEN_OFS)) begin
        pend_lsn_d  = 1'b1;
        pend_talk_d = 1'b0;
        talk_d      = 1'b0;
        // remote only on listen address with REN
        if (bus.ren) begin
          rem_d = 1'b1;
        end
      end else if (cmd_w == GDCD_CMD_UNT) begin
        talk_d      = 1'b0;
        pend_talk_d = 1'b0;
      end else if (cmd_w[6:5] == 2'b10) begin
        talk_d      = 1'b0;
        pend_talk_d = 1'b0;
      end else if (cmd_w == GDCD_CMD_UNL) begin
        lsn_d      = 1'b0;
        pend_lsn_d = 1'b0;
      end else if (cmd_w == GDCD_CMD_DCL) begin
        evt_d.dev_clear = 1'b1;
        rp_d = wp_d;
        // service request kept only for power-on
        srq_d = srq_q & srq_pwr_on;
      end else if (cmd_w == GDCD_CMD_LLO) begin
        if (bus.ren) begin
          llo_d = 1'b1;
        end
      end else if (cmd_w == GDCD_CMD_SPE) begin
        spe_d = 1'b1;
      end else if (cmd_w == GDCD_CMD_SPD) begin
        spe_d = 1'b0;
      end else if (lsn_q || pend_lsn_q) begin
        if (cmd_w == GDCD_CMD_GET) begin
          evt_d.trigger = 1'b1;
        end else if (cmd_w == GDCD_CMD_GTL) begin
          evt_d.go_local = 1'b1;
          rem_d = 1'b0;
        end else if (cmd_w == GDCD_CMD_SDC) begin
          evt_d.sel_clear = 1'b1;
          rp_d = wp_d;
        end
      end
    end
    // Pending roles take effect once ATN releases
    if (!bus.atn) begin
      if (pend_talk_q) begin
        talk_d = 1'b1;
      end
      if (pend_lsn_q) begin
        lsn_d = 1'b1;
      end
      pend_talk_d = 1'b0;
      pend_lsn_d  = 1'b0;
    end
    if (!bus.ren) begin
      llo_d = 1'b0;
      rem_d = 1'b0;
    end
    if (bus.ifc) begin
      talk_d      = 1'b0;
      lsn_d       = 1'b0;
      spe_d       = 1'b0;
      pend_talk_d = 1'b0;
      pend_lsn_d  = 1'b0;
    end
    rv_d = (wp_q != rp_d);
  end

  // Listener handshake: NDAC held until byte taken, NRFD during acceptance
  always_comb begin
    hs_d   = hs_q;
    ndac_d = 1'b1;
    nrfd_d = 1'b0;
    case (hs_q)
      GDCD_HS_IDLE: begin
        if (byte_w && (bus.atn || (lsn_q && !full_w))) begin
          hs_d = GDCD_HS_ACCEPT;
        end
      end
      GDCD_HS_ACCEPT: begin
        hs_d = GDCD_HS_WAIT_DROP;
      end
      GDCD_HS_WAIT_DROP: begin
        if (!bus.dav) begin
          hs_d = GDCD_HS_IDLE;
        end
      end
      default: hs_d = GDCD_HS_IDLE;
    endcase
    if (hs_d != GDCD_HS_IDLE) begin
      ndac_d = 1'b0;
      nrfd_d = 1'b1;
    end
    if (lsn_d && !bus.atn && (full_w || wr_w && (wp_d[AW-1:0] ==
        rp_d[AW-1:0]))) begin
      nrfd_d = 1'b1;
    end
    // drive only as talker with ATN off
    doe_d  = talk_q && !bus.atn && !bus.ifc;
    // status byte replaces data during serial poll
    dout_d = spe_q ? status_byte : talk_data;
    if (!doe_d || (!spe_q && !talk_valid)) begin
      doe_d  = doe_d && spe_q;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      talk_q      <= 1'b0;
      lsn_q       <= 1'b0;
      spe_q       <= 1'b0;
      rem_q       <= 1'b0;
      llo_q       <= 1'b0;
      pend_talk_q <= 1'b0;
      pend_lsn_q  <= 1'b0;
      wp_q        <= '0;
      rp_q        <= '0;
      rv_q        <= 1'b0;
      srq_q       <= 1'b0;
      evt_q       <= '0;
      hs_q        <= GDCD_HS_IDLE;
      ndac_q      <= 1'b0;
      nrfd_q      <= 1'b0;
      doe_q       <= 1'b0;
      dout_q      <= 8'h00;
      dav_q       <= 1'b0;
      fx_q        <= 1'b0;
    end else begin
      talk_q      <= talk_d;
      lsn_q       <= lsn_d;
      spe_q       <= spe_d;
      rem_q       <= rem_d;
      llo_q       <= llo_d;
      pend_talk_q <= pend_talk_d;
      pend_lsn_q  <= pend_lsn_d;
      wp_q        <= wp_d;
      rp_q        <= rp_d;
      rv_q        <= rv_d;
      srq_q       <= srq_d;
      evt_q       <= evt_d;
      hs_q        <= hs_d;
      ndac_q      <= ndac_d;
      nrfd_q      <= nrfd_d;
      doe_q       <= doe_d;
      dout_q      <= dout_d;
      dav_q       <= bus.dav;
      fx_q        <= fast_xmit_in;
    end
  end

  assign dio_out   = dout_q;
  assign dio_oe    = doe_q;
  assign nrfd_oe   = nrfd_q;
  assign ndac_oe   = ndac_q;
  assign srq_oe    = srq_q;
  assign rd_valid  = rv_q;
  assign talker    = talk_q;
  assign listener  = lsn_q;
  assign spoll     = spe_q;
  assign remote    = rem_q;
  assign lockout   = llo_q;
  assign fast_xmit = fx_q;
  assign evt       = evt_q;
endmodule // gdcd_top

//--- design/gdcd_pkg.sv
/*
  Package of the GPIB device command decoder: command codes, address
  offsets, structs carrying bus lines and user-side signals.
  Assumes bus lines already resolved to active-high levels.
*/
package gdcd_pkg;

  localparam logic [6:0] GDCD_CMD_GTL   = 7'h01;
  localparam logic [6:0] GDCD_CMD_SDC   = 7'h04;
  localparam logic [6:0] GDCD_CMD_GET   = 7'h08;
  localparam logic [6:0] GDCD_CMD_TCT   = 7'h09;
  localparam logic [6:0] GDCD_CMD_LLO   = 7'h11;
  localparam logic [6:0] GDCD_CMD_DCL   = 7'h14;
  localparam logic [6:0] GDCD_CMD_SPE   = 7'h18;
  localparam logic [6:0] GDCD_CMD_SPD   = 7'h19;
  localparam logic [6:0] GDCD_CMD_UNL   = 7'h3F;
  localparam logic [6:0] GDCD_CMD_UNT   = 7'h5F;
  localparam logic [6:0] GDCD_LISTEN_OFS = 7'h20;
  localparam logic [6:0] GDCD_TALK_OFS   = 7'h40;
  localparam logic [4:0] GDCD_ADDR_MAX   = 5'h1E;
  localparam logic [4:0] GDCD_ADDR_RST   = 5'h00;

  // Synchronised management, handshake and data lines, active high
  typedef struct packed {
    logic       atn;
    logic       ifc;
    logic       ren;
    logic       dav;
    logic [7:0] dio;
  } gdcd_bus_t;

  // One-cycle action pulses toward the instrument
  typedef struct packed {
    logic dev_clear;
    logic sel_clear;
    logic trigger;
    logic go_local;
  } gdcd_evt_t;

  typedef enum logic [1:0] {
    GDCD_HS_IDLE,
    GDCD_HS_ACCEPT,
    GDCD_HS_WAIT_DROP
  } gdcd_hs_t;

endpackage

//--- design/gdcd_sync.sv
/*
  Two flip-flop synchroniser for a group of pin inputs.
  Assumes inputs are asynchronous to clk.
*/
`timescale 1ns/1ps
module gdcd_sync #(
  parameter int WIDTH = 12
) (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] sync_q;

  if (WIDTH < 1) begin : g_width_bad
    $error("gdcd_sync WIDTH must be positive");
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= async_in;
      sync_q <= meta_q;
    end
  end

  assign sync_out = sync_q;
endmodule // gdcd_sync

//--- design/gdcd_mem.sv
/*
  Small register-read memory used as the listener input buffer store.
  Assumes one writer and one reader on the same clock.
*/
`timescale 1ns/1ps
module gdcd_mem #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input  wire logic                     clk,
  input  wire logic                     wr_en,
  input  wire logic [$clog2(DEPTH)-1:0] wr_addr,
  input  wire logic [WIDTH-1:0]         wr_data,
  input  wire logic [$clog2(DEPTH)-1:0] rd_addr,
  output logic      [WIDTH-1:0]         rd_data
);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [WIDTH-1:0] rd_q;

  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_depth_bad
    $error("gdcd_mem DEPTH must be a power of two, at least 2");
  end

  always_ff @(posedge clk) begin
    if (wr_en) begin
      mem_q[wr_addr] <= wr_data;
    end
    rd_q <= mem_q[rd_addr];
  end

  assign rd_data = rd_q;
endmodule // gdcd_mem

//--- tb/gdcd_checker.sv
/* Port checker for gdcd_top, bound into every instance.
   Assumes one clock clk and synchronous active-high reset rst. */
`timescale 1ns/1ps
module gdcd_checker
  import gdcd_pkg::*;
(
  input wire logic      clk,
  input wire logic      rst,
  input wire logic      atn_pin,
  input wire logic      ifc_pin,
  input wire logic      ren_pin,
  input wire logic      srq_pwr_on,
  input wire logic      fast_xmit_in,
  input wire logic      dio_oe,
  input wire logic      ndac_oe,
  input wire logic      nrfd_oe,
  input wire logic      srq_oe,
  input wire logic      talker,
  input wire logic      listener,
  input wire logic      spoll,
  input wire logic      remote,
  input wire logic      lockout,
  input wire logic      fast_xmit,
  input wire gdcd_evt_t evt
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  a_atn_drive_off:
    assert property (atn_pin [*5] |=> !dio_oe) else $error("drive under atn");
  a_drive_needs_talk:
    assert property (dio_oe |-> $past(talker)) else $error("drive not talker");
  a_ifc_unaddress:
    assert property (ifc_pin [*5] |=> !(talker || listener || spoll))
      else $error("state kept under ifc");
  a_ren_unlock:
    assert property (!ren_pin [*5] |=> !(lockout || remote))
      else $error("lock kept without ren");
  a_lock_needs_ren:
    assert property ($rose(lockout) |-> ren_pin && $past(ren_pin, 4))
      else $error("lock without ren");
  a_addr_cmd_listen:
    assert property ((evt.trigger || evt.sel_clear || evt.go_local)
      |-> listener) else $error("addressed event not listener");
  a_evt_one_cycle:
    assert property (4'(evt) != 4'h0 |=> 4'(evt) == 4'h0)
      else $error("event longer than a cycle");
  a_accept_holds_nrfd:
    assert property ($fell(ndac_oe) |-> nrfd_oe) else $error("nrfd not held");
  a_dcl_drops_srq:
    assert property (evt.dev_clear && !srq_pwr_on |-> ##[0:2] !srq_oe)
      else $error("srq kept after clear");
  a_dcl_keeps_fast:
    assert property (evt.dev_clear && fast_xmit_in |=> fast_xmit)
      else $error("fast mode lost on clear");

  c_trigger: cover property (evt.trigger);
  c_lockout: cover property ($rose(lockout));
  c_poll_drive: cover property (spoll && dio_oe);
  c_dev_clear: cover property (evt.dev_clear);
endmodule // gdcd_checker

bind gdcd_top gdcd_checker gdcd_checker_i (.clk, .rst, .atn_pin, .ifc_pin,
  .ren_pin, .srq_pwr_on, .fast_xmit_in, .dio_oe, .ndac_oe, .nrfd_oe,
  .srq_oe, .talker, .listener, .spoll, .remote, .lockout, .fast_xmit, .evt);

//--- tb/gdcd_ctl.sv
/* Controller model: attention, clear, remote enable, byte handshake.
   Assumes the device answers on nrfd_oe and ndac_oe, high = held. */
`timescale 1ns/1ps
module gdcd_ctl (
  input  wire logic       clk,
  input  wire logic       nrfd_oe,
  input  wire logic       ndac_oe,
  output logic            atn,
  output logic            ifc,
  output logic            ren,
  output logic            dav,
  output logic      [7:0] dio
);
  initial begin
    {atn, ifc, ren, dav} = 4'h0;
    dio = 8'hFF;
  end

  task automatic lines(input logic a, input logic i, input logic r);
    @(posedge clk);
    {atn, ifc, ren} <= {a, i, r};
    repeat (8) @(posedge clk);
  endtask

  task automatic xfer(input logic a, input logic [7:0] b, input int gap,
                      output logic ok);
    int n;
    n = 0;
    ok = 1'b0;
    @(posedge clk);
    atn <= a;
    dio <= b;
    repeat (gap + 3) @(posedge clk);
    while (nrfd_oe && n < 40) begin
      @(posedge clk);
      n++;
    end
    if (!nrfd_oe) begin
      dav <= 1'b1;
      repeat (40) begin
        @(posedge clk);
        if (!ndac_oe) break;
      end
      ok = !ndac_oe;
      dav <= 1'b0;
      // Released lines show the inverse
      dio <= ~b;
      repeat (40) begin
        @(posedge clk);
        if (ndac_oe) break;
      end
    end
  endtask
endmodule // gdcd_ctl

//--- tb/gdcd_top_tb.sv
/* Self-checking bench of gdcd_top with the controller model.
   Assumes the checker file and gdcd_ctl are compiled first. */
`timescale 1ns/1ps
module gdcd_top_tb
  import gdcd_pkg::*;
;
  localparam int DEPTH = 8;
  localparam int LIMIT = 20000;
  logic       clk = 1'b0, rst = 1'b1, clr = 1'b0, ok, talk_valid = 1'b1;
  logic       srq_req = 1'b0, srq_pwr_on = 1'b0, fast_xmit_in = 1'b0;
  logic       rd_ready = 1'b0, atn_pin, ifc_pin, ren_pin, dav_pin;
  logic       dio_oe, nrfd_oe, ndac_oe, srq_oe, rd_valid, talker;
  logic       listener, spoll, remote, lockout, fast_xmit;
  logic [4:0] pa, prim_addr = 5'h00;
  logic [7:0] talk_data = 8'h00, status_byte = 8'h00;
  logic [7:0] bus_dio, dio_pin_in, dio_out, rd_data;
  logic [3:0] seen = 4'h0;
  gdcd_evt_t  evt;
  int         failures = 0, total_checks = 0, cyc = 0;
  logic [6:0] ac [4] = '{GDCD_CMD_GET, GDCD_CMD_SDC, GDCD_CMD_GTL,
                         GDCD_CMD_TCT};
  logic [3:0] ae [4] = '{4'h2, 4'h4, 4'h1, 4'h0};

  always #5 clk = ~clk;
  assign dio_pin_in = dio_oe ? dio_out : bus_dio;

  gdcd_top #(.DEPTH(DEPTH)) gdcd_top_i (.clk, .rst, .prim_addr, .atn_pin,
    .ifc_pin, .ren_pin, .dav_pin, .dio_pin_in, .dio_out, .dio_oe, .nrfd_oe,
    .ndac_oe, .srq_oe, .talk_valid, .talk_data, .status_byte, .srq_req,
    .srq_pwr_on, .fast_xmit_in, .rd_ready, .rd_valid, .rd_data, .talker,
    .listener, .spoll, .remote, .lockout, .fast_xmit, .evt);
  gdcd_ctl gdcd_ctl_i (.clk, .nrfd_oe, .ndac_oe, .atn(atn_pin),
    .ifc(ifc_pin), .ren(ren_pin), .dav(dav_pin), .dio(bus_dio));

  task automatic complete_run();
    if (failures == 0 && total_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // Whole sequence takes under two thousand cycles
  always @(posedge clk) begin
    cyc <= cyc + 1;
    seen <= clr ? 4'h0 : seen | 4'(evt);
    if (cyc == LIMIT) begin
      failures++;
      complete_run();
    end
  end

  task automatic chk(input string what, input logic [7:0] exp, got);
    total_checks++;
    if (got !== exp) begin
      failures++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic cmd(input logic [6:0] c);
    clr <= 1'b1;
    @(posedge clk);
    clr <= 1'b0;
    gdcd_ctl_i.xfer(1'b1, {1'($urandom), c}, $urandom % 3, ok);
  endtask

  task automatic dat(input logic [7:0] d);
    gdcd_ctl_i.xfer(1'b0, d, $urandom % 3, ok);
  endtask

  task automatic addr(input logic [6:0] ofs);
    cmd(ofs + 7'(pa));
    gdcd_ctl_i.lines(1'b0, 1'b0, ren_pin);
  endtask

  task automatic pop();
    @(posedge clk);
    rd_ready <= 1'b1;
    @(posedge clk);
    rd_ready <= 1'b0;
    repeat (2) @(posedge clk);
  endtask

  initial begin
    void'($urandom(32'h188CD35E));
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    repeat (4) @(posedge clk);
    for (int k = 0; k < 3; k++) begin
      pa = k == 0 ? GDCD_ADDR_RST : k == 1 ? GDCD_ADDR_MAX : 5'($urandom % 31);
      prim_addr <= pa;
      talk_data <= 8'($urandom);
      addr(GDCD_LISTEN_OFS);
      chk("listener", 8'h01, 8'(listener));
      dat(talk_data);
      chk("rd_data", talk_data, rd_data);
      pop();
      addr(GDCD_TALK_OFS);
      chk("talker", 8'h01, 8'(talker));
      chk("drive", 8'h01, {7'h00, dio_oe});
      chk("dio_out", talk_data, dio_out);
      addr(GDCD_LISTEN_OFS);
      chk("listener", 8'h01, 8'(listener));
      addr(GDCD_TALK_OFS);
      cmd(GDCD_TALK_OFS + 7'(pa == GDCD_ADDR_MAX ? 5'h00 : pa + 5'h01));
      chk("talker", 8'h00, 8'(talker));
      addr(GDCD_TALK_OFS);
      cmd(GDCD_CMD_UNT);
      chk("talker", 8'h00, 8'(talker));
      addr(GDCD_LISTEN_OFS);
      cmd(GDCD_CMD_UNL);
      chk("listener", 8'h00, 8'(listener));
      dat(8'hA5);
      chk("taken", 8'h00, 8'(ok));
      chk("drive", 8'h00, {7'h00, dio_oe});
    end
    addr(GDCD_LISTEN_OFS);
    srq_req <= 1'b1;
    srq_pwr_on <= 1'b1;
    fast_xmit_in <= 1'b1;
    repeat (DEPTH) begin
      dat(8'($urandom));
      chk("taken", 8'h01, 8'(ok));
    end
    dat(8'h3C);
    chk("full", 8'h01, 8'({ok, nrfd_oe}));
    pop();
    dat(8'h3C);
    chk("taken", 8'h01, 8'(ok));
    pop();
    cmd(GDCD_CMD_DCL);
    chk("clear", 8'h43, 8'({seen, rd_valid, srq_oe, fast_xmit}));
    for (int l = 0; l < 2; l++) begin
      for (int k = 0; k < 4; k++) begin
        if (l == 0)
          addr(GDCD_LISTEN_OFS);
        else
          cmd(GDCD_CMD_UNL);
        cmd(ac[k]);
        chk("evt", l == 0 ? 8'(ae[k]) : 8'h00, 8'(seen));
      end
    end
    status_byte <= 8'($urandom);
    cmd(GDCD_CMD_SPE);
    addr(GDCD_TALK_OFS);
    chk("spoll", 8'h01, 8'(spoll));
    chk("drive", 8'h01, {7'h00, dio_oe});
    chk("dio_out", status_byte, dio_out);
    cmd(GDCD_CMD_SPD);
    gdcd_ctl_i.lines(1'b0, 1'b0, 1'b0);
    chk("spoll", 8'h00, 8'(spoll));
    chk("dio_out", talk_data, dio_out);
    cmd(GDCD_CMD_SPE);
    addr(GDCD_LISTEN_OFS);
    gdcd_ctl_i.lines(1'b0, 1'b1, 1'b0);
    chk("ifc", 8'h00, 8'({talker, listener, spoll}));
    gdcd_ctl_i.lines(1'b0, 1'b0, 1'b1);
    chk("remote", 8'h00, 8'(remote));
    cmd(GDCD_CMD_LLO);
    addr(GDCD_LISTEN_OFS);
    cmd(GDCD_CMD_GTL);
    chk("lockout", 8'h01, 8'(lockout));
    srq_pwr_on <= 1'b0;
    cmd(GDCD_CMD_DCL);
    gdcd_ctl_i.lines(1'b0, 1'b0, 1'b0);
    chk("unlock", 8'h00, 8'({lockout, remote}));
    cmd(GDCD_CMD_LLO);
    chk("lockout", 8'h00, 8'(lockout));
    complete_run();
  end
endmodule // gdcd_top_tb
